// >>> bcc_codec_pkg.sv
// Constants, frame layouts and carrier types for the bearer connection control message codec.
// Assumes octets travel one per beat; bit 8 of an octet is bit [7] here.
package bcc_codec_pkg;
	localparam logic [7:0] PROTO_DISC = 8'h48;
	localparam logic [7:0] MT_FAULT_REPORT = 8'h28;
	localparam logic [7:0] MT_FAULT_ACK = 8'h29;
	localparam logic [7:0] MT_PROTO_ERROR = 8'h2A;
	localparam logic [7:0] IE_USER_PORT = 8'h40;
	localparam logic [7:0] IE_ISDN_CHAN = 8'h41;
	localparam logic [7:0] IE_TIME_SLOT = 8'h42;
	localparam logic [7:0] IE_MULTI_SLOT = 8'h43;
	localparam logic [7:0] IE_REJECT = 8'h44;
	localparam logic [7:0] IE_ERR_CAUSE = 8'h45;
	localparam logic [7:0] IE_INCOMPLETE = 8'h46;
	localparam logic [7:0] LEN_USER_PORT = 8'h02;
	localparam logic [7:0] LEN_TIME_SLOT = 8'h02;
	localparam logic [7:0] LEN_ERR_CAUSE = 8'h02;
	localparam logic [7:0] CAUSE_RESERVED_IE = 8'h01;
	localparam logic [7:0] CAUSE_REF_FORMAT = 8'h02;
	localparam logic [7:0] CAUSE_TRUNCATED = 8'h03;
	localparam logic [7:0] CAUSE_UNKNOWN_TYPE = 8'h04;
	localparam int REF_W = 13;
	localparam int REF_HI_W = 7;
	localparam int REF_LO_W = 6;
	localparam int ANA_PORT_W = 15;
	localparam int ISDN_PORT_W = 13;
	localparam int FRAME_MAX = 12;
	localparam logic [3:0] FRAME_LEN_BASE = 4'h8;
	localparam logic [3:0] FRAME_LEN_SLOT = 4'hC;
	localparam logic [3:0] FRAME_LEN_ERR = 4'h8;
	localparam int HOLD_CYCLES_DEFAULT = 10000;

	typedef struct packed {
		logic creator;
		logic [REF_W-1:0] value;
	} ref_num_t;

	typedef struct packed {
		logic isdn;
		logic [ANA_PORT_W-1:0] port_id;
		logic slot_valid;
		logic [7:0] link_id;
		logic [4:0] slot;
	} fault_req_t;

	typedef struct packed {
		logic last;
		logic [7:0] data;
	} octet_t;
endpackage

// >>> bcc_octet_fifo.sv
// Synchronous FIFO for outgoing octets with valid/ready on both sides.
// Assumes one clock; full and empty are exact, push is refused while full.
`timescale 1ns/1ps
module bcc_octet_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("FIFO depth must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(pop);
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // bcc_octet_fifo

// >>> bcc_ref_alloc.sv
// Reference number allocator for processes opened by the access side.
// Assumes one process open at a time; release comes from ack or cancel.
`timescale 1ns/1ps
module bcc_ref_alloc #(
	parameter int HOLD_CYCLES = bcc_codec_pkg::HOLD_CYCLES_DEFAULT
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic alloc,
	input wire logic release_ref,
	input wire logic taint,
	output logic free,
	output logic [bcc_codec_pkg::REF_W-1:0] active_ref
);
	localparam int CW = $clog2(HOLD_CYCLES + 1);
	generate
		if (HOLD_CYCLES < 1) begin : g_bad_hold
			$error("HOLD_CYCLES must be at least 1");
		end
	endgenerate

	logic busy_q;
	logic tainted_q;
	logic [CW-1:0] hold_q;

	assign free = !busy_q && (hold_q == '0);

	// Sequential generation; one open process means no value can collide
	// Advancing on release keeps the value ready for the frame built at alloc
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			active_ref <= '0;
		end else if (busy_q && release_ref) begin
			active_ref <= active_ref + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy_q <= 1'b0;
			tainted_q <= 1'b0;
			hold_q <= '0;
		end else begin
			if (alloc && free) begin
				busy_q <= 1'b1;
				tainted_q <= 1'b0;
			end else if (busy_q && release_ref) begin
				busy_q <= 1'b0;
				tainted_q <= 1'b0;
				if (tainted_q || taint) begin
					hold_q <= CW'(HOLD_CYCLES);
				end
			end else if (busy_q && taint) begin
				tainted_q <= 1'b1;
			end
			if (hold_q != '0 && !(busy_q && release_ref)) begin
				hold_q <= hold_q - 1'b1;
			end
		end
	end
endmodule // bcc_ref_alloc

// >>> bcc_msg_codec.sv
// Access-side codec: builds fault reports and protocol error messages,
// parses incoming messages and reports acknowledgements and errors.
// Assumes octet streams with a last marker; inputs synchronous to clk.
`timescale 1ns/1ps
module bcc_msg_codec #(
	parameter int HOLD_CYCLES = bcc_codec_pkg::HOLD_CYCLES_DEFAULT,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic fault_req_valid,
	input wire bcc_codec_pkg::fault_req_t fault_req,
	output logic fault_req_ready,
	input wire logic fault_cancel,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	output logic in_ready,
	output logic out_valid,
	output logic [7:0] out_data,
	output logic out_last,
	input wire logic out_ready,
	output logic fault_ack_pulse,
	output logic proto_err_pulse,
	output logic [7:0] proto_err_cause,
	output bcc_codec_pkg::ref_num_t active_ref
);
	typedef enum logic [2:0] {
		RX_PD = 3'b000,
		RX_REF_HI = 3'b001,
		RX_REF_LO = 3'b010,
		RX_TYPE = 3'b011,
		RX_IE_ID = 3'b100,
		RX_IE_LEN = 3'b101,
		RX_IE_BODY = 3'b110,
		RX_DISCARD = 3'b111
	} rx_state_t;

	// Receive side
	rx_state_t rx_q;
	bcc_codec_pkg::ref_num_t rx_ref_q;
	logic [7:0] rx_type_q;
	logic [7:0] rx_left_q;
	logic rx_take;
	logic rx_err;
	logic [7:0] rx_cause;
	logic rx_end_ok;

	// Pending protocol error message
	logic err_pend_q;
	bcc_codec_pkg::ref_num_t err_ref_q;
	logic [7:0] err_cause_q;
	logic [7:0] err_type_q;

	// Transmit frame builder
	logic [7:0] frame_q [bcc_codec_pkg::FRAME_MAX];
	logic [3:0] frame_len_q;
	logic [3:0] frame_idx_q;
	logic tx_busy_q;
	logic take_fault;
	logic take_err;
	logic [7:0] port_hi;
	logic [7:0] port_lo;
	logic [7:0] ref_hi;
	logic [7:0] ref_lo;

	// Reference allocation
	logic ref_free;
	logic [bcc_codec_pkg::REF_W-1:0] ref_value;
	logic ack_hit;
	logic taint_active;

	// Buffer and output stage
	bcc_codec_pkg::octet_t fifo_in;
	bcc_codec_pkg::octet_t fifo_out;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic push;

	assign rx_take = in_valid && in_ready;

	// Parser step: error detection per octet
	always_comb begin
		rx_err = 1'b0;
		rx_cause = bcc_codec_pkg::CAUSE_TRUNCATED;
		if (rx_take) begin
			unique case (rx_q)
				RX_REF_LO: begin
					if (in_data[7:6] != 2'b00) begin
						rx_err = 1'b1;
						rx_cause = bcc_codec_pkg::CAUSE_REF_FORMAT;
					end else if (in_last) begin
						rx_err = 1'b1;
					end
				end
				RX_TYPE: begin
					if (in_data != bcc_codec_pkg::MT_FAULT_ACK) begin
						rx_err = 1'b1;
						rx_cause = bcc_codec_pkg::CAUSE_UNKNOWN_TYPE;
					end
				end
				RX_IE_ID: begin
					if (in_data[7] || in_data < bcc_codec_pkg::IE_USER_PORT
							|| in_data > bcc_codec_pkg::IE_INCOMPLETE) begin
						rx_err = 1'b1;
						rx_cause = bcc_codec_pkg::CAUSE_RESERVED_IE;
					end else if (in_last) begin
						rx_err = 1'b1;
					end
				end
				RX_IE_LEN: begin
					rx_err = in_last && (in_data != 8'h00);
				end
				RX_IE_BODY: begin
					rx_err = in_last && (rx_left_q != 8'h01);
				end
				RX_REF_HI: begin
					rx_err = in_last;
				end
				RX_PD, RX_DISCARD: begin
					rx_err = 1'b0;
				end
			endcase
		end
	end

	// Message closes cleanly on an element boundary
	always_comb begin
		rx_end_ok = 1'b0;
		if (rx_take && in_last && !rx_err) begin
			unique case (rx_q)
				RX_TYPE: rx_end_ok = 1'b1;
				RX_IE_LEN: rx_end_ok = 1'b1;
				RX_IE_BODY: rx_end_ok = 1'b1;
				default: rx_end_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_q <= RX_PD;
			rx_ref_q <= '0;
			rx_type_q <= 8'h00;
			rx_left_q <= 8'h00;
		end else if (rx_take) begin
			unique case (rx_q)
				RX_PD: begin
					// Foreign discriminators belong to other protocols
					if (in_last) begin
						rx_q <= RX_PD;
					end else if (in_data == bcc_codec_pkg::PROTO_DISC) begin
						rx_q <= RX_REF_HI;
					end else begin
						rx_q <= RX_DISCARD;
					end
				end
				RX_REF_HI: begin
					rx_ref_q.creator <= in_data[7];
					rx_ref_q.value[bcc_codec_pkg::REF_W-1 -: bcc_codec_pkg::REF_HI_W] <=
						in_data[bcc_codec_pkg::REF_HI_W-1:0];
					rx_q <= in_last ? RX_PD : RX_REF_LO;
				end
				RX_REF_LO: begin
					rx_ref_q.value[bcc_codec_pkg::REF_LO_W-1:0] <=
						in_data[bcc_codec_pkg::REF_LO_W-1:0];
					rx_q <= in_last ? RX_PD : (rx_err ? RX_DISCARD : RX_TYPE);
				end
				RX_TYPE: begin
					rx_type_q <= in_data;
					rx_q <= in_last ? RX_PD : (rx_err ? RX_DISCARD : RX_IE_ID);
				end
				RX_IE_ID: begin
					rx_q <= in_last ? RX_PD : (rx_err ? RX_DISCARD : RX_IE_LEN);
				end
				RX_IE_LEN: begin
					rx_left_q <= in_data;
					if (in_last) begin
						rx_q <= RX_PD;
					end else begin
						rx_q <= (in_data == 8'h00) ? RX_IE_ID : RX_IE_BODY;
					end
				end
				RX_IE_BODY: begin
					rx_left_q <= rx_left_q - 8'h01;
					if (in_last) begin
						rx_q <= RX_PD;
					end else begin
						rx_q <= (rx_left_q == 8'h01) ? RX_IE_ID : RX_IE_BODY;
					end
				end
				RX_DISCARD: begin
					rx_q <= in_last ? RX_PD : RX_DISCARD;
				end
			endcase
		end
	end

	// Ack must name our own open process: creator set, value equal
	assign ack_hit = rx_end_ok && rx_ref_q.creator && !ref_free
		&& (rx_ref_q.value == ref_value)
		&& ((rx_q == RX_TYPE) ? (in_data == bcc_codec_pkg::MT_FAULT_ACK)
			: (rx_type_q == bcc_codec_pkg::MT_FAULT_ACK));
	assign taint_active = rx_err && rx_q != RX_REF_HI && rx_q != RX_REF_LO
		&& rx_ref_q.creator && (rx_ref_q.value == ref_value);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fault_ack_pulse <= 1'b0;
			proto_err_pulse <= 1'b0;
			proto_err_cause <= 8'h00;
			in_ready <= 1'b0;
		end else begin
			// Arrival only; the failed bearer stays the exchange's business
			fault_ack_pulse <= ack_hit;
			proto_err_pulse <= rx_err;
			if (rx_err) begin
				proto_err_cause <= rx_cause;
			end
			in_ready <= 1'b1;
		end
	end

	// One pending error; a second error while one is pending is dropped
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			err_pend_q <= 1'b0;
			err_ref_q <= '0;
			err_cause_q <= 8'h00;
			err_type_q <= 8'h00;
		end else if (rx_err && !err_pend_q) begin
			err_pend_q <= 1'b1;
			err_cause_q <= rx_cause;
			err_ref_q.creator <= (rx_q == RX_REF_HI) ? in_data[7] : rx_ref_q.creator;
			err_ref_q.value <= rx_ref_q.value;
			err_type_q <= (rx_q == RX_TYPE) ? in_data : rx_type_q;
		end else if (take_err) begin
			err_pend_q <= 1'b0;
		end
	end

	bcc_ref_alloc #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_ref (
		.clk(clk),
		.resetn(resetn),
		.alloc(take_fault),
		.release_ref(ack_hit || fault_cancel),
		.taint(taint_active),
		.free(ref_free),
		.active_ref(ref_value)
	);

	assign take_fault = fault_req_valid && fault_req_ready;
	assign take_err = err_pend_q && !tx_busy_q && !take_fault;

	// Port element octets three and four
	always_comb begin
		if (fault_req.isdn) begin
			port_hi = {1'b0, fault_req.port_id[bcc_codec_pkg::ISDN_PORT_W-1:8], 2'b00};
		end else begin
			port_hi = {fault_req.port_id[bcc_codec_pkg::ANA_PORT_W-1:8], 1'b1};
		end
		port_lo = fault_req.port_id[7:0];
	end

	// Reference octets for outgoing messages
	always_comb begin
		if (take_fault) begin
			ref_hi = {1'b1, ref_value[bcc_codec_pkg::REF_W-1 -: bcc_codec_pkg::REF_HI_W]};
			ref_lo = {2'b00, ref_value[bcc_codec_pkg::REF_LO_W-1:0]};
		end else begin
			ref_hi = {err_ref_q.creator,
				err_ref_q.value[bcc_codec_pkg::REF_W-1 -: bcc_codec_pkg::REF_HI_W]};
			ref_lo = {2'b00, err_ref_q.value[bcc_codec_pkg::REF_LO_W-1:0]};
		end
	end

	// Only package identifiers are loaded, so nothing reserved is sent
	always_ff @(posedge clk) begin
		if (take_fault || take_err) begin
			frame_q[0] <= bcc_codec_pkg::PROTO_DISC;
			frame_q[1] <= ref_hi;
			frame_q[2] <= ref_lo;
		end
		if (take_fault) begin
			frame_q[3] <= bcc_codec_pkg::MT_FAULT_REPORT;
			frame_q[4] <= bcc_codec_pkg::IE_USER_PORT;
			frame_q[5] <= bcc_codec_pkg::LEN_USER_PORT;
			frame_q[6] <= port_hi;
			frame_q[7] <= port_lo;
			frame_q[8] <= bcc_codec_pkg::IE_TIME_SLOT;
			frame_q[9] <= bcc_codec_pkg::LEN_TIME_SLOT;
			frame_q[10] <= fault_req.link_id;
			frame_q[11] <= {3'b000, fault_req.slot};
		end else if (take_err) begin
			frame_q[3] <= bcc_codec_pkg::MT_PROTO_ERROR;
			frame_q[4] <= bcc_codec_pkg::IE_ERR_CAUSE;
			frame_q[5] <= bcc_codec_pkg::LEN_ERR_CAUSE;
			frame_q[6] <= err_cause_q;
			frame_q[7] <= err_type_q;
		end
	end

	assign push = tx_busy_q && fifo_in_ready;
	assign fifo_in.data = frame_q[frame_idx_q];
	assign fifo_in.last = (frame_idx_q == frame_len_q - 4'h1);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_busy_q <= 1'b0;
			frame_len_q <= 4'h0;
			frame_idx_q <= 4'h0;
		end else if (take_fault || take_err) begin
			tx_busy_q <= 1'b1;
			frame_idx_q <= 4'h0;
			if (take_err) begin
				frame_len_q <= bcc_codec_pkg::FRAME_LEN_ERR;
			end else if (fault_req.slot_valid) begin
				frame_len_q <= bcc_codec_pkg::FRAME_LEN_SLOT;
			end else begin
				frame_len_q <= bcc_codec_pkg::FRAME_LEN_BASE;
			end
		end else if (push) begin
			frame_idx_q <= frame_idx_q + 4'h1;
			if (fifo_in.last) begin
				tx_busy_q <= 1'b0;
			end
		end
	end

	// Registered ready: a request is never taken while a frame is in build
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fault_req_ready <= 1'b0;
		end else begin
			fault_req_ready <= !take_fault && !take_err && ref_free
				&& (!tx_busy_q || (push && fifo_in.last));
		end
	end

	bcc_octet_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(tx_busy_q),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	assign fifo_pop = fifo_out_valid && (!out_valid || out_ready);

	// Output register keeps every link output on a flop
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			out_data <= 8'h00;
			out_last <= 1'b0;
		end else if (!out_valid || out_ready) begin
			out_valid <= fifo_out_valid;
			out_data <= fifo_out.data;
			out_last <= fifo_out.last;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			active_ref <= '0;
		end else begin
			active_ref.creator <= !ref_free;
			active_ref.value <= ref_value;
		end
	end
endmodule // bcc_msg_codec

// >>> bcc_codec_assertions.sv
// Checker for the codec top: frame layout, reference fields and event pulses.
// Assumes it is bound to bcc_msg_codec and sees only that module's ports.
`timescale 1ns/1ps
module bcc_codec_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic fault_req_valid,
	input wire logic fault_req_ready,
	input wire logic out_valid,
	input wire logic [7:0] out_data,
	input wire logic out_last,
	input wire logic out_ready,
	input wire logic fault_ack_pulse,
	input wire logic proto_err_pulse,
	input wire bcc_codec_pkg::ref_num_t active_ref
);
	logic [3:0] beat_q;
	logic rpt_q;
	wire logic fire = out_valid && out_ready;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			beat_q <= 4'h0;
		end else if (fire) begin
			beat_q <= out_last ? 4'h0 : beat_q + 4'h1;
		end
	end

	// Marks a report frame, so echoed error headers are not judged here
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rpt_q <= 1'b0;
		end else if (fault_req_valid && fault_req_ready) begin
			rpt_q <= 1'b1;
		end else if (fire && out_last) begin
			rpt_q <= 1'b0;
		end
	end

	chk_pd_first: assert property (
		out_valid && beat_q == 4'h0 |-> out_data == bcc_codec_pkg::PROTO_DISC)
		else $error("frame does not open with discriminator");
	chk_ref_high: assert property (
		rpt_q && out_valid && beat_q == 4'h1 |-> out_data == {1'b1, active_ref.value[12:6]})
		else $error("reference high octet wrong");
	chk_ref_low: assert property (
		rpt_q && out_valid && beat_q == 4'h2 |-> out_data == {2'b00, active_ref.value[5:0]})
		else $error("reference low octet wrong");
	chk_report_type: assert property (
		rpt_q && out_valid && beat_q == 4'h3 |-> out_data == bcc_codec_pkg::MT_FAULT_REPORT)
		else $error("report type octet wrong");
	chk_port_ident: assert property (
		rpt_q && fire && beat_q == 4'h4 |-> out_data == bcc_codec_pkg::IE_USER_PORT)
		else $error("port element identifier wrong");
	chk_port_len: assert property (
		rpt_q && fire && beat_q == 4'h5 |-> out_data == bcc_codec_pkg::LEN_USER_PORT)
		else $error("port element length wrong");
	chk_frame_length: assert property (
		fire && out_last |-> beat_q == 4'h7 || beat_q == 4'hB)
		else $error("frame length not 8 or 12");
	chk_out_hold: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
		else $error("output octet changed while stalled");
	chk_ack_single: assert property (
		fault_ack_pulse |=> !fault_ack_pulse)
		else $error("ack pulse longer than one cycle");
	chk_ack_closes: assert property (
		fault_ack_pulse |-> ##[0:2] !active_ref.creator)
		else $error("process still open after ack");
	chk_one_open: assert property (
		active_ref.creator |-> !fault_req_ready)
		else $error("request accepted while process open");

	cover property (fault_ack_pulse);
	cover property (proto_err_pulse);
	cover property (fire && out_last && beat_q == 4'hB);
	cover property (out_valid && !out_ready);
endmodule // bcc_codec_checker

bind bcc_msg_codec bcc_codec_checker chk (
	.clk(clk),
	.resetn(resetn),
	.fault_req_valid(fault_req_valid),
	.fault_req_ready(fault_req_ready),
	.out_valid(out_valid),
	.out_data(out_data),
	.out_last(out_last),
	.out_ready(out_ready),
	.fault_ack_pulse(fault_ack_pulse),
	.proto_err_pulse(proto_err_pulse),
	.active_ref(active_ref)
);

// >>> bcc_exchange_model.sv
// Exchange-side peer: sinks outgoing frames, answers reports, injects queued octets.
// Assumes the bench queues injected messages whole and sets slow, stall and auto_ack.
`timescale 1ns/1ps
module bcc_exchange_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic out_valid,
	input wire logic [7:0] out_data,
	input wire logic out_last,
	output logic out_ready = 1'b0,
	output logic in_valid = 1'b0,
	output logic [7:0] in_data = 8'h00,
	output logic in_last = 1'b0,
	input wire logic in_ready
);
	logic slow = 1'b0;
	logic stall = 1'b0;
	logic auto_ack = 1'b1;
	logic [7:0] rx[12];
	logic [8:0] txq[$];
	logic [1:0] tick_q = 2'h0;
	int cnt = 0;
	int rx_len = 0;
	int frames = 0;

	task automatic push(input logic [7:0] d, input logic l);
		txq.push_back({l, d});
	endtask

	always @(posedge clk) begin
		tick_q <= tick_q + 2'h1;
		// Slow mode takes one octet in four
		out_ready <= resetn && !stall && (!slow || tick_q == 2'h0);
		if (resetn && out_valid && out_ready) begin
			rx[cnt] <= out_data;
			cnt <= out_last ? 0 : cnt + 1;
			if (out_last) begin
				rx_len <= cnt + 1;
				frames <= frames + 1;
			end
			// Arrival alone is acknowledged, no repair is implied
			if (out_last && auto_ack && rx[3] == bcc_codec_pkg::MT_FAULT_REPORT) begin
				push(bcc_codec_pkg::PROTO_DISC, 1'b0);
				push(rx[1], 1'b0);
				push(rx[2], 1'b0);
				push(bcc_codec_pkg::MT_FAULT_ACK, 1'b1);
			end
		end
		if (!resetn) begin
			in_valid <= 1'b0;
		end else if (!in_valid || in_ready) begin
			if (txq.size() > 0) begin
				{in_last, in_data} <= txq.pop_front();
				in_valid <= 1'b1;
			end else begin
				// Idle line toggles so stale data is never mistaken
				in_valid <= 1'b0;
				in_last <= 1'b0;
				in_data <= ~in_data;
			end
		end
	end
endmodule // bcc_exchange_model

// >>> bcc_msg_codec_tb_top.sv
// Bench for the codec: report frames, ack matching, error replies and the buffer.
// Assumes the exchange model on the far side; the buffer is reached through the top.
`timescale 1ns/1ps
module bcc_msg_codec_tb_top;
	typedef struct packed {
		bcc_codec_pkg::fault_req_t req;
		logic slow;
	} row_t;
	typedef struct packed {
		logic [55:0] msg;
		logic [3:0] len;
		logic [7:0] cause;
	} err_row_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic fault_req_valid = 1'b0;
	bcc_codec_pkg::fault_req_t fault_req = '0;
	logic fault_cancel = 1'b0;
	logic in_valid, in_last, in_ready, out_valid, out_last, out_ready;
	logic [7:0] in_data, out_data, proto_err_cause;
	logic fault_req_ready, fault_ack_pulse, proto_err_pulse;
	bcc_codec_pkg::ref_num_t active_ref;
	int err_count = 0;
	int num_checks = 0;
	int acks = 0;
	int errs = 0;
	logic [7:0] e[12];
	row_t rows[4] = '{'{'{1'b0, 15'h7ABC, 1'b0, 8'h00, 5'h00}, 1'b0},
		'{'{1'b0, 15'h0001, 1'b1, 8'hFF, 5'h1F}, 1'b1},
		'{'{1'b1, 15'h1FFF, 1'b1, 8'h01, 5'h01}, 1'b0},
		'{'{1'b1, 15'h0100, 1'b0, 8'h00, 5'h00}, 1'b1}};
	err_row_t erows[6] = '{'{56'h4880012B000000, 4'h4, 8'h04},
		'{56'h4880C129000000, 4'h4, 8'h02}, '{56'h48800129470000, 4'h6, 8'h01},
		'{56'h48800129C00000, 4'h6, 8'h01}, '{56'h48800129400200, 4'h7, 8'h03},
		'{56'h48800000000000, 4'h2, 8'h03}};

	always #5 clk = ~clk;

	bcc_msg_codec #(.HOLD_CYCLES(20), .FIFO_DEPTH(16)) dut (.clk(clk), .resetn(resetn),
		.fault_req_valid(fault_req_valid), .fault_req(fault_req),
		.fault_req_ready(fault_req_ready), .fault_cancel(fault_cancel), .in_valid(in_valid),
		.in_data(in_data), .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid),
		.out_data(out_data), .out_last(out_last), .out_ready(out_ready),
		.fault_ack_pulse(fault_ack_pulse), .proto_err_pulse(proto_err_pulse),
		.proto_err_cause(proto_err_cause), .active_ref(active_ref));
	bcc_exchange_model model (.clk(clk), .resetn(resetn), .out_valid(out_valid),
		.out_data(out_data), .out_last(out_last), .out_ready(out_ready),
		.in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready));

	always @(negedge clk) begin
		if (fault_ack_pulse === 1'b1) acks++;
		if (proto_err_pulse === 1'b1) errs++;
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic send_req(input bcc_codec_pkg::fault_req_t r);
		int k;
		k = 0;
		@(posedge clk);
		fault_req_valid <= 1'b1;
		fault_req <= r;
		@(negedge clk);
		while (fault_req_ready !== 1'b1 && k < 200) begin
			@(negedge clk);
			k++;
		end
		@(posedge clk);
		fault_req_valid <= 1'b0;
	endtask

	task automatic wait_frames(input int n);
		int k;
		k = 0;
		while (model.frames < n && k < 500) begin
			@(negedge clk);
			k++;
		end
		check("frames", 16'(model.frames), 16'(n));
	endtask

	task automatic push_msg(input logic [55:0] m, input int len);
		for (int i = 0; i < len; i++) model.push(m[55-8*i -: 8], i == len - 1);
	endtask

	task automatic send_ack(input logic c, input logic [12:0] v);
		push_msg({bcc_codec_pkg::PROTO_DISC, c, v[12:6], 2'b00, v[5:0],
			bcc_codec_pkg::MT_FAULT_ACK, 24'h000000}, 4);
	endtask

	task automatic build(input bcc_codec_pkg::fault_req_t q, input logic [12:0] v);
		e[0] = bcc_codec_pkg::PROTO_DISC;
		e[1] = {1'b1, v[12:6]};
		e[2] = {2'b00, v[5:0]};
		e[3] = bcc_codec_pkg::MT_FAULT_REPORT;
		e[4] = bcc_codec_pkg::IE_USER_PORT;
		e[5] = bcc_codec_pkg::LEN_USER_PORT;
		e[6] = q.isdn ? {1'b0, q.port_id[12:8], 2'b00} : {q.port_id[14:8], 1'b1};
		e[7] = q.port_id[7:0];
		e[8] = bcc_codec_pkg::IE_TIME_SLOT;
		e[9] = bcc_codec_pkg::LEN_TIME_SLOT;
		e[10] = q.link_id;
		e[11] = {3'b000, q.slot};
	endtask

	initial begin
		cycles(11);
		check("ready_in_reset", {15'h0, fault_req_ready}, 16'h0);
		check("in_ready_in_reset", {15'h0, in_ready}, 16'h0);
		check("valid_in_reset", {15'h0, out_valid}, 16'h0);
		@(posedge clk);
		resetn <= 1'b1;
		cycles(3);
		check("in_ready_after", {15'h0, in_ready}, 16'h1);
		$display("reset test done");
		for (int r = 0; r < 4; r++) begin
			model.slow <= rows[r].slow;
			build(rows[r].req, 13'(r));
			send_req(rows[r].req);
			wait_frames(r + 1);
			check("ref_open", 16'(active_ref), {2'b00, 1'b1, 13'(r)});
			check("frame_len", 16'(model.rx_len), rows[r].req.slot_valid ? 16'd12 : 16'd8);
			for (int i = 0; i < 12; i++) begin
				if (i < model.rx_len) check("octet", {8'h00, model.rx[i]}, {8'h00, e[i]});
			end
			cycles(12);
			check("acks", 16'(acks), 16'(r + 1));
			check("ref_closed", {15'h0, active_ref.creator}, 16'h0);
			$display("report row %0d done", r);
		end
		// Wrong value and exchange-created acks must not close the process
		model.auto_ack <= 1'b0;
		send_req(rows[0].req);
		wait_frames(5);
		send_ack(1'b1, 13'd5);
		send_ack(1'b0, 13'd4);
		cycles(16);
		check("ack_ignored", 16'(acks), 16'd4);
		check("ready_while_open", {15'h0, fault_req_ready}, 16'h0);
		@(posedge clk);
		fault_cancel <= 1'b1;
		@(posedge clk);
		fault_cancel <= 1'b0;
		cycles(4);
		check("ready_after_cancel", {15'h0, fault_req_ready}, 16'h1);
		send_req(rows[2].req);
		wait_frames(6);
		check("ref_not_reused", 16'(active_ref), {2'b00, 1'b1, 13'd5});
		send_ack(1'b1, 13'd5);
		cycles(12);
		check("ack_matched", 16'(acks), 16'd5);
		$display("ack matching test done");
		for (int k = 0; k < 7; k++) push_msg({32'h48800129, 8'h40 + 8'(k), 16'h0000}, 6);
		cycles(60);
		check("assigned_ids", 16'(errs), 16'd0);
		$display("element id test done");
		for (int r = 0; r < 6; r++) begin
			push_msg(erows[r].msg, int'(erows[r].len));
			wait_frames(7 + r);
			check("err_pulses", 16'(errs), 16'(r + 1));
			check("cause", {8'h00, proto_err_cause}, {8'h00, erows[r].cause});
			check("err_type", {8'h00, model.rx[3]}, {8'h00, bcc_codec_pkg::MT_PROTO_ERROR});
			check("err_ie", {8'h00, model.rx[4]}, {8'h00, bcc_codec_pkg::IE_ERR_CAUSE});
			check("err_cause_oct", {8'h00, model.rx[6]}, {8'h00, erows[r].cause});
			check("err_len", 16'(model.rx_len), 16'd8);
		end
		$display("error reply test done");
		// Output held back: report plus error reply are more than the buffer holds
		model.stall <= 1'b1;
		build(rows[1].req, 13'd6);
		send_req(rows[1].req);
		push_msg(erows[0].msg, 4);
		cycles(40);
		check("stall_frames", 16'(model.frames), 16'd12);
		check("stall_hold", {7'h00, out_valid, out_data}, 16'h0148);
		model.stall <= 1'b0;
		wait_frames(13);
		check("buf_len", 16'(model.rx_len), 16'd12);
		for (int i = 0; i < 12; i++) check("buf_octet", {8'h00, model.rx[i]}, {8'h00, e[i]});
		wait_frames(14);
		check("buf_err_type", {8'h00, model.rx[3]}, {8'h00, bcc_codec_pkg::MT_PROTO_ERROR});
		check("buf_err_cause", {8'h00, model.rx[6]}, 16'h0004);
		cycles(4);
		check("buf_empty", {15'h0, out_valid}, 16'h0);
		$display("buffer test done");
		finish_test();
	end

	// Whole run needs under a thousand cycles
	initial begin
		#100000;
		err_count++;
		finish_test();
	end
endmodule // bcc_msg_codec_tb_top
